// File: shared/adcwc_pkg.sv
package adcwc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    // The system clock and the fastest allowed conversion clock, in hertz.
    localparam int unsigned HCLK_HZ = 25_000_000;
    localparam int unsigned SAR_CLK_MAX_HZ = 3_000_000;
    // Divider rounds up so the conversion clock never exceeds its maximum.
    localparam int unsigned SAR_DIV = (HCLK_HZ + SAR_CLK_MAX_HZ - 1) / SAR_CLK_MAX_HZ;
    // Conversion clocks spent on one conversion.
    localparam int unsigned CONV_SAR_CLOCKS = 10;
    // System clock cycles from an accepted start to the result.
    localparam int unsigned CONV_CYCLES = SAR_DIV * CONV_SAR_CLOCKS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);

    // ----------------------------------------------------------------
    // Data widths
    // ----------------------------------------------------------------
    localparam int CODE_W = 10;
    localparam int WORD_W = 16;
    localparam int JUST_SHIFT = WORD_W - CODE_W;

    // ----------------------------------------------------------------
    // Register map, byte offsets within the slave window
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_GREATER = 8'h08;
    localparam logic [7:0] OFS_LESS = 8'h0C;
    localparam logic [7:0] OFS_RESULT = 8'h10;

    // Converter control register fields; the mask register shares the layout.
    localparam int CTRL_DIFF_BIT = 0;
    localparam int CTRL_LEFT_BIT = 1;
    localparam int CTRL_START_BIT = 2;
    localparam int CTRL_HIT_BIT = 3;
    localparam int CTRL_DONE_BIT = 4;

    // Limits reset to an empty inside window so nothing hits after reset.
    localparam logic [WORD_W-1:0] GREATER_RST = 16'h0000;
    localparam logic [WORD_W-1:0] LESS_RST = 16'h0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } adcwc_fsm_t;

    // Held sample from the analog front end with its start strobe.
    typedef struct packed {
        logic start;
        logic [CODE_W-1:0] code;
    } adcwc_sample_t;

    typedef struct packed {
        adcwc_fsm_t fsm;
        logic [CNT_W-1:0] cnt;
        logic [CODE_W-1:0] code;
        logic diff;
        logic left;
        logic hit;
        logic done;
        logic [1:0] mask;
        logic [WORD_W-1:0] greater;
        logic [WORD_W-1:0] less;
        logic [WORD_W-1:0] result;
        logic wr_pend;
        logic [7:0] wr_ofs;
        logic [31:0] rdata;
        logic hready;
        logic hresp;
        logic irq;
    } adcwc_state_t;

    localparam adcwc_state_t STATE_RST = '{
        fsm: ST_IDLE,
        cnt: '0,
        code: '0,
        diff: 1'b0,
        left: 1'b0,
        hit: 1'b0,
        done: 1'b0,
        mask: 2'h0,
        greater: GREATER_RST,
        less: LESS_RST,
        result: '0,
        wr_pend: 1'b0,
        wr_ofs: 8'h00,
        rdata: 32'h0000_0000,
        hready: 1'b1,
        hresp: 1'b0,
        irq: 1'b0
    };

endpackage : adcwc_pkg

// File: sim/tb_adc_window_comparator.sv
`timescale 1ns/10ps
module tb_adc_window_comparator;
    import adcwc_pkg::*;

    // ----------------------------------------------------------------
    // Signals and design instance
    // ----------------------------------------------------------------
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, hit_acc;
    logic [31:0] haddr, hwdata, hrdata, seed, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    adcwc_sample_t sample;
    int n_fail, check_count;

    // A single slave, so its ready is the bus ready.
    assign hready = hreadyout;

    adcwc_top adcwc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .sample(sample),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // ----------------------------------------------------------------
    // Expectation helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Justified result word as software sees it.
    function automatic logic [15:0] exp_word(input logic [9:0] c, input logic d, input logic lj);
        if (lj) return {c, 6'h00};
        return d ? {{6{c[9]}}, c} : {6'h00, c};
    endfunction : exp_word

    function automatic logic lt(input logic [15:0] a, input logic [15:0] b, input logic d);
        return d ? ($signed(a) < $signed(b)) : (a < b);
    endfunction : lt

    // Limit order picks inside or outside detection; equal limits never hit.
    function automatic logic exp_hit(input logic [15:0] w, input logic [15:0] g, input logic [15:0] l,
        input logic d);
        if (lt(g, l, d)) return lt(g, w, d) && lt(w, l, d);
        if (lt(l, g, d)) return lt(w, l, d) || lt(g, w, d);
        return 1'b0;
    endfunction : exp_hit

    // ----------------------------------------------------------------
    // Reporting and bus tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One idle cycle first, so a read never follows a write's address phase directly.
    // Ready and read data are taken as they stand at the rising edge, before it updates them.
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rdat);
        int n;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h000000, ofs};
        rdat = 32'h00000000;
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
                if (n > 50) begin
                    n_fail++;
                    conclude();
                end
            end while (hready !== 1'b1);
            if (ph == 0) begin
                hsel <= 1'b0;
                htrans <= 2'b00;
                hwdata <= wd;
            end else begin
                rdat = hrdata;
            end
        end
    endtask : bus

    // Program limits and mode, start, time the conversion, check result, flags and interrupt.
    task automatic run(input logic [9:0] c, input logic d, input logic lj, input logic via,
        input logic [15:0] g, input logic [15:0] l);
        logic [15:0] w;
        int n;
        w = exp_word(c, d, lj);
        hit_acc = hit_acc | exp_hit(w, g, l, d);
        bus(1'b1, OFS_GREATER, {16'h0000, g}, rd);
        bus(1'b1, OFS_LESS, {16'h0000, l}, rd);
        bus(1'b1, OFS_CTRL, {27'h0000000, 3'b100, lj, d}, rd);
        bus(1'b1, OFS_MASK, 32'h00000010, rd);
        sample.code <= c;
        if (via) begin
            bus(1'b1, OFS_CTRL, {27'h0000000, 3'b001, lj, d}, rd);
        end else begin
            sample.start <= 1'b1;
            @(posedge hclk);
            sample.start <= 1'b0;
        end
        n = 0;
        do begin
            @(posedge hclk);
            n++;
            @(negedge hclk);
            if (n > 300) begin
                n_fail++;
                conclude();
            end
        end while (irq !== 1'b1);
        chk(n, CONV_CYCLES, "conversion length");
        bus(1'b0, OFS_RESULT, 32'h00000000, rd);
        chk(rd, {16'h0000, w}, "result word");
        bus(1'b0, OFS_CTRL, 32'h00000000, rd);
        chk(rd, {27'h0000000, 1'b1, hit_acc, 1'b0, lj, d}, "ctrl flags");
        bus(1'b1, OFS_MASK, 32'h00000008, rd);
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk({31'h00000000, irq}, {31'h00000000, hit_acc}, "hit irq");
    endtask : run

    task automatic clear_check();
        bus(1'b1, OFS_CTRL, 32'h00000018, rd);
        bus(1'b0, OFS_CTRL, 32'h00000000, rd);
        hit_acc = 1'b0;
        chk(rd, 32'h00000000, "ctrl after clear");
        @(negedge hclk);
        chk({31'h00000000, irq}, 32'h00000000, "irq after clear");
    endtask : clear_check

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        hsize = 3'b010;
        sample = '0;
        hresetn = 1'b0;
        hit_acc = 1'b0;
        n_fail = 0;
        check_count = 0;
        seed = 32'h6F43F4E6;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values, then the read-only result and an unmapped word ignore writes.
        for (int a = 0; a < 6; a++) begin
            bus(1'b0, 8'(a * 4), 32'h00000000, rd);
            chk(rd, 32'h00000000, "reset value");
        end
        bus(1'b1, OFS_RESULT, 32'hFFFFFFFF, rd);
        bus(1'b1, 8'h14, 32'hFFFFFFFF, rd);
        for (int a = 4; a < 6; a++) begin
            bus(1'b0, 8'(a * 4), 32'h00000000, rd);
            chk(rd, 32'h00000000, "ignored write");
        end
        // Limits are always written in the format of the active mode.
        foreach (seed[i]) begin
            if (i < 4) begin
                run(10'h040 + 10'(i * 63) / 2, 1'b0, 1'b0, 1'b0, 16'h0040, 16'h0080);
                clear_check();
                run(10'h03F + 10'(i * 33), 1'b0, 1'b0, i[0], 16'h0080, 16'h0040);
                clear_check();
                run(10'h3FF + 10'(i * 31), 1'b1, 1'b0, 1'b0, 16'hFFFF, 16'h0040);
                clear_check();
                run(10'h3FE + 10'(i * 35), 1'b1, 1'b0, 1'b0, 16'h0040, 16'hFFFF);
                clear_check();
                run(10'h040 + 10'(i), i[1], 1'b1, 1'b0, 16'h1000, 16'h2000);
                clear_check();
            end
        end
        run(10'h041, 1'b0, 1'b0, 1'b0, 16'h0040, 16'h0040);
        run(10'h050, 1'b0, 1'b0, 1'b1, 16'h0040, 16'h0080);
        run(10'h000, 1'b0, 1'b0, 1'b0, 16'h0040, 16'h0080);
        // A conversion in flight reads back as busy; let it finish before clearing.
        @(posedge hclk);
        sample.start <= 1'b1;
        @(posedge hclk);
        sample.start <= 1'b0;
        bus(1'b0, OFS_CTRL, 32'h00000000, rd);
        chk(rd & 32'h00000004, 32'h00000004, "busy bit");
        repeat (CONV_CYCLES) @(posedge hclk);
        clear_check();
        for (int i = 0; i < 16; i++) begin
            seed = lfsr_next(seed);
            rd = lfsr_next(seed);
            run(seed[9:0], seed[10], seed[11], seed[12], exp_word(rd[9:0], seed[10], seed[11]),
                exp_word(rd[25:16], seed[10], seed[11]));
            if (seed[13]) clear_check();
        end
        conclude();
    end

    // A hung sequence counts as a mismatch.
    initial begin
        repeat (90000) @(posedge hclk);
        n_fail++;
        conclude();
    end

endmodule : tb_adc_window_comparator

// File: src/adcwc_top.sv
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
module adcwc_top
    import adcwc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire adcwc_sample_t sample,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic irq
);

    adcwc_state_t st_q;
    adcwc_state_t st_d;
    logic fin;
    logic acc;
    logic wr_ctrl;
    logic start;
    logic cmp_hit;
    logic [WORD_W-1:0] res_w;

    // Justify a raw code: sign or zero extend, or shift to the top of the word.
    function automatic logic [WORD_W-1:0] justify(input logic [CODE_W-1:0] code, input logic diff,
                                                  input logic left);
        if (left) begin
            justify = {code, {JUST_SHIFT{1'b0}}};
        end else begin
            justify = {{JUST_SHIFT{diff & code[CODE_W-1]}}, code};
        end
    endfunction : justify

    // ----------------------------------------------------------------
    // Window comparator
    // ----------------------------------------------------------------
    adcwc_window u_window (
        .sample_word(res_w),
        .greater(st_q.greater),
        .less(st_q.less),
        .signed_mode(st_q.diff),
        .hit(cmp_hit)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Bus, conversion sequencer and flags share one next-state process.
    always_comb begin
        st_d = st_q;
        fin = (st_q.fsm == ST_CONV) && (st_q.cnt == '0);
        res_w = justify(st_q.code, st_q.diff, st_q.left);
        acc = hsel && htrans[1] && hready;
        wr_ctrl = st_q.wr_pend && (st_q.wr_ofs == OFS_CTRL);
        start = sample.start || (wr_ctrl && hwdata[CTRL_START_BIT]);

        // Address phase: latch write target, fetch read data for the data phase.
        st_d.wr_pend = acc && hwrite;
        if (acc) begin
            st_d.wr_ofs = haddr[7:0];
        end
        st_d.rdata = 32'h0000_0000;
        if (acc && !hwrite) begin
            unique case (haddr[7:0])
                OFS_CTRL: begin
                    st_d.rdata[CTRL_DIFF_BIT] = st_q.diff;
                    st_d.rdata[CTRL_LEFT_BIT] = st_q.left;
                    st_d.rdata[CTRL_START_BIT] = (st_q.fsm == ST_CONV);
                    st_d.rdata[CTRL_HIT_BIT] = st_q.hit;
                    st_d.rdata[CTRL_DONE_BIT] = st_q.done;
                end
                OFS_MASK: begin
                    st_d.rdata[CTRL_HIT_BIT] = st_q.mask[0];
                    st_d.rdata[CTRL_DONE_BIT] = st_q.mask[1];
                end
                OFS_GREATER: st_d.rdata[WORD_W-1:0] = st_q.greater;
                OFS_LESS: st_d.rdata[WORD_W-1:0] = st_q.less;
                OFS_RESULT: st_d.rdata[WORD_W-1:0] = st_q.result;
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end

        // Data phase writes. Flags clear on a written one; a set below wins.
        if (wr_ctrl) begin
            st_d.diff = hwdata[CTRL_DIFF_BIT];
            st_d.left = hwdata[CTRL_LEFT_BIT];
            if (hwdata[CTRL_HIT_BIT]) begin
                st_d.hit = 1'b0;
            end
            if (hwdata[CTRL_DONE_BIT]) begin
                st_d.done = 1'b0;
            end
        end
        if (st_q.wr_pend && (st_q.wr_ofs == OFS_MASK)) begin
            st_d.mask = {hwdata[CTRL_DONE_BIT], hwdata[CTRL_HIT_BIT]};
        end
        if (st_q.wr_pend && (st_q.wr_ofs == OFS_GREATER)) begin
            st_d.greater = hwdata[WORD_W-1:0];
        end
        if (st_q.wr_pend && (st_q.wr_ofs == OFS_LESS)) begin
            st_d.less = hwdata[WORD_W-1:0];
        end

        // Conversion sequencer; a start during a conversion is ignored.
        unique case (st_q.fsm)
            ST_IDLE: begin
                if (start) begin
                    st_d.fsm = ST_CONV;
                    st_d.cnt = CONV_LAST;
                    st_d.code = sample.code;
                end
            end
            ST_CONV: begin
                if (fin) begin
                    st_d.fsm = ST_IDLE;
                    st_d.result = res_w;
                    st_d.done = 1'b1;
                    if (cmp_hit) begin
                        st_d.hit = 1'b1;
                    end
                end else begin
                    st_d.cnt = st_q.cnt - CNT_W'(1);
                end
            end
        endcase

        // The interrupt follows the flags as they will stand next cycle.
        st_d.irq = |({st_d.done, st_d.hit} & st_d.mask);
        st_d.hready = 1'b1;
        st_d.hresp = 1'b0;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Every field resets to a constant; the analog code is taken only on start.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state register.
    assign hreadyout = st_q.hready;
    assign hrdata = st_q.rdata;
    assign hresp = st_q.hresp;
    assign irq = st_q.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    localparam int CONV_LAT = int'(CONV_CYCLES);
    localparam int CONV_LAT_M1 = CONV_LAT - 1;
    logic busy;
    logic clr_hit;
    assign busy = (st_q.fsm == ST_CONV);
    assign clr_hit = wr_ctrl && hwdata[CTRL_HIT_BIT];

    property p_conv_len;
        $rose(busy) |-> ##CONV_LAT_M1 busy ##1 !busy;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

    property p_se_inside;
        fin && !st_q.diff && (st_q.greater < st_q.less) && (res_w > st_q.greater) && (res_w < st_q.less)
            |=> st_q.hit;
    endproperty
    a_se_inside: assert property (p_se_inside) else $error("inside hit missed");

    property p_se_outside;
        fin && !st_q.diff && (st_q.greater > st_q.less) && ((res_w < st_q.less) || (res_w > st_q.greater))
            |=> st_q.hit;
    endproperty
    a_se_outside: assert property (p_se_outside) else $error("outside hit missed");

    property p_se_unsigned;
        fin && !st_q.diff && !st_q.left |=> (st_q.result[WORD_W-1:CODE_W] == '0) && st_q.done;
    endproperty
    a_se_unsigned: assert property (p_se_unsigned) else $error("unsigned result not zero extended");

    property p_diff_extend;
        fin && st_q.diff && !st_q.left |=> st_q.result[WORD_W-1:CODE_W] == {JUST_SHIFT{st_q.result[CODE_W-1]}};
    endproperty
    a_diff_extend: assert property (p_diff_extend) else $error("differential result not sign extended");

    property p_diff_inside;
        fin && st_q.diff && ($signed(st_q.greater) < $signed(st_q.less))
            && ($signed(res_w) > $signed(st_q.greater)) && ($signed(res_w) < $signed(st_q.less)) |=> st_q.hit;
    endproperty
    a_diff_inside: assert property (p_diff_inside) else $error("signed inside hit missed");

    property p_diff_outside;
        fin && st_q.diff && ($signed(st_q.greater) > $signed(st_q.less))
            && (($signed(res_w) < $signed(st_q.less)) || ($signed(res_w) > $signed(st_q.greater)))
            |=> st_q.hit;
    endproperty
    a_diff_outside: assert property (p_diff_outside) else $error("signed outside hit missed");

    property p_no_false_hit;
        !st_q.hit && !(fin && cmp_hit) |=> !st_q.hit;
    endproperty
    a_no_false_hit: assert property (p_no_false_hit) else $error("hit flag set without a hit");

    property p_hit_sticky;
        st_q.hit && !clr_hit |=> st_q.hit;
    endproperty
    a_hit_sticky: assert property (p_hit_sticky) else $error("hit flag dropped without a clear");

    property p_left_low_zero;
        fin && st_q.left |=> (st_q.result[JUST_SHIFT-1:0] == '0)
            && (st_q.result[WORD_W-1:JUST_SHIFT] == $past(st_q.code));
    endproperty
    a_left_low_zero: assert property (p_left_low_zero) else $error("left-justified word wrong");

    property p_auto_compare;
        $rose(busy) |-> ##CONV_LAT st_q.done;
    endproperty
    a_auto_compare: assert property (p_auto_compare) else $error("conversion did not complete");

    property p_irq_level;
        ##1 (irq == |({st_q.done, st_q.hit} & st_q.mask));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt does not follow flags");

    // A result that misses the window leaves a clear flag clear. These work from the
    // limits and the result word alone, so a wrong comparator cannot hide behind them.
    property p_se_inside_miss;
        fin && !st_q.hit && !st_q.diff && (st_q.greater < st_q.less)
            && ((res_w <= st_q.greater) || (res_w >= st_q.less)) |=> !st_q.hit;
    endproperty
    a_se_inside_miss: assert property (p_se_inside_miss) else $error("inside window false hit");

    property p_se_outside_miss;
        fin && !st_q.hit && !st_q.diff && (res_w >= st_q.less) && (res_w <= st_q.greater) |=> !st_q.hit;
    endproperty
    a_se_outside_miss: assert property (p_se_outside_miss) else $error("outside window false hit");

    property p_diff_inside_miss;
        fin && !st_q.hit && st_q.diff && ($signed(st_q.greater) < $signed(st_q.less))
            && (($signed(res_w) <= $signed(st_q.greater)) || ($signed(res_w) >= $signed(st_q.less)))
            |=> !st_q.hit;
    endproperty
    a_diff_inside_miss: assert property (p_diff_inside_miss) else $error("signed inside false hit");

    property p_diff_outside_miss;
        fin && !st_q.hit && st_q.diff && ($signed(res_w) >= $signed(st_q.less))
            && ($signed(res_w) <= $signed(st_q.greater)) |=> !st_q.hit;
    endproperty
    a_diff_outside_miss: assert property (p_diff_outside_miss) else $error("signed outside false hit");

    property p_done_at_fin;
        fin |=> st_q.done && !busy;
    endproperty
    a_done_at_fin: assert property (p_done_at_fin) else $error("completion did not set done");

    property p_result_hold;
        !fin |=> $stable(st_q.result);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed without a completion");

    // The sample is frozen for the whole conversion; a start while busy is dropped.
    property p_code_hold;
        busy |=> $stable(st_q.code);
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("sample changed during a conversion");

    // Read data stands only in the data phase of a read and is zero otherwise.
    property p_rdata_idle;
        !(acc && !hwrite) |=> (hrdata == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read data phase");

    property p_greater_write;
        st_q.wr_pend && (st_q.wr_ofs == OFS_GREATER) |=> (st_q.greater == $past(hwdata[WORD_W-1:0]));
    endproperty
    a_greater_write: assert property (p_greater_write) else $error("greater limit write lost");

    property p_less_write;
        st_q.wr_pend && (st_q.wr_ofs == OFS_LESS) |=> (st_q.less == $past(hwdata[WORD_W-1:0]));
    endproperty
    a_less_write: assert property (p_less_write) else $error("less limit write lost");

    c_hit_inside: cover property (fin && cmp_hit && (st_q.greater < st_q.less));
    c_hit_outside: cover property (fin && cmp_hit && (st_q.greater > st_q.less));
    c_hit_diff: cover property (fin && cmp_hit && st_q.diff);
    c_hit_clear: cover property (st_q.hit && clr_hit ##1 !st_q.hit);
    c_irq_rise: cover property ($rose(irq));

endmodule : adcwc_top

// File: src/adcwc_window.sv
`timescale 1ns/10ps
module adcwc_window
    import adcwc_pkg::*;
(
    input wire logic [WORD_W-1:0] sample_word,
    input wire logic [WORD_W-1:0] greater,
    input wire logic [WORD_W-1:0] less,
    input wire logic signed_mode,
    output logic hit
);

    // Strict less-than, signed or unsigned over the whole justified word.
    function automatic logic below(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b, input logic sgn);
        below = sgn ? ($signed(a) < $signed(b)) : (a < b);
    endfunction : below

    // ----------------------------------------------------------------
    // Window decision
    // ----------------------------------------------------------------
    // The order of the two limits alone picks inside or outside; equal limits
    // form an empty inside window, so no result hits.
    always_comb begin
        if (below(less, greater, signed_mode)) begin
            // Outside arrangement: the gap between the limits is the only quiet band.
            hit = below(sample_word, less, signed_mode)
                || below(greater, sample_word, signed_mode);
        end else begin
            hit = below(greater, sample_word, signed_mode) && below(sample_word, less, signed_mode);
        end
    end

endmodule : adcwc_window
